// ---- tig_pkg.sv ----
// Constants, field layout and helpers for the timer interrupt gate
package tig_pkg;

    // -------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h00;
    localparam logic [7:0] ADDR_FLAGS        = 8'h04;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_EVENT_MASK   = 8'h0C;

    // -------------------------------------------------------------
    // Field positions, shared by all four registers
    // -------------------------------------------------------------
    localparam int unsigned REG_W         = 6;
    localparam int unsigned BIT_MATCH_C   = 2;
    localparam int unsigned BIT_MATCH_D   = 3;
    localparam int unsigned BIT_OVERFLOW  = 4;
    localparam int unsigned BIT_UNDERFLOW = 5;

    // -------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------
    localparam logic [5:0]  IRQ_ENABLE_RST = 6'h00;
    localparam logic [5:0]  EVENT_RST      = 6'h00;
    localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

    typedef logic [REG_W-1:0] tig_field_t;

    // Channels that own compare/capture C and D
    function automatic logic has_match_cd(input int unsigned ch);
        return (ch == 0) || (ch == 3);
    endfunction

    // Bits that exist and accept writes in the given channel
    function automatic tig_field_t writable_mask(input int unsigned ch);
        tig_field_t m;
        m = 6'h00;
        m[BIT_OVERFLOW] = 1'b1;
        if (has_match_cd(ch))
        begin
            m[BIT_MATCH_C] = 1'b1;
            m[BIT_MATCH_D] = 1'b1;
        end
        else
        begin
            m[BIT_UNDERFLOW] = 1'b1;
        end
        return m;
    endfunction

endpackage

// ---- tig_reg_if.sv ----
// Register access carrier between the bus slave and the gate core
`timescale 1ns/1ns
interface tig_reg_if;
    logic        wr_pulse;
    logic        rd_pulse;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        hit;

    modport bus
    (
        output wr_pulse,
        output rd_pulse,
        output addr,
        output wdata,
        input  rdata,
        input  hit
    );

    modport core
    (
        input  wr_pulse,
        input  rd_pulse,
        input  addr,
        input  wdata,
        output rdata,
        output hit
    );
endinterface

// ---- tig_apb_slave.sv ----
// APB slave front end with one-cycle registered answer
`timescale 1ns/1ns
module tig_apb_slave
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    // APB answer
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core side
    tig_reg_if.bus           rb
);

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tig_apb_s;

    tig_apb_s st_r;
    tig_apb_s st_nxt;
    logic     setup;
    logic     done;

    assign setup       = psel && !penable;
    assign done        = psel && penable && st_r.pready;
    assign rb.addr     = paddr;
    assign rb.wdata    = pwdata;
    assign rb.wr_pulse = done && pwrite;
    assign rb.rd_pulse = done && !pwrite;

    always_comb
    begin
        st_nxt = st_r;
        if (setup)
        begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !rb.hit;
            st_nxt.prdata  = (pwrite || !rb.hit) ? tig_pkg::RDATA_RST
                                                 : rb.rdata;
        end
        else if (done)
        begin
            st_nxt.pready  = 1'b0;
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = tig_pkg::RDATA_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        else
            st_r <= st_nxt;
    end

    assign prdata  = st_r.prdata;
    assign pready  = st_r.pready;
    assign pslverr = st_r.pslverr;

    // Answer comes exactly one edge after the setup cycle
    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("APB answer not ready after setup");

endmodule // tig_apb_slave

// ---- tig_gate.sv ----
// Flag and enable gating with registered requests and rise events
`timescale 1ns/1ns
module tig_gate
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Status flags and enables, field layout of the enable register
    input  wire logic [5:0] flags,
    input  wire logic [5:0] enable,
    // Gated requests and one-cycle rise events
    output logic      [5:0] irq_req,
    output logic      [5:0] evt
);

    typedef struct packed {
        logic [5:0] irq;
    } tig_gate_s;

    tig_gate_s st_r;
    tig_gate_s st_nxt;

    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.irq = flags & enable;            // R08
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '{irq: 6'h00};
        else
            st_r <= st_nxt;
    end

    assign irq_req = st_r.irq;
    assign evt     = st_nxt.irq & ~st_r.irq;

    gate_and_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq_req == $past(flags & enable)) // R08
        else $error("Request is not flag AND enable");

endmodule // tig_gate

// ---- tig_timer_irq_gate.sv ----
// Top of one timer channel's interrupt enable gating with APB registers
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns

// Summary of operation
// (R01) Bit 4 enables the overflow request, is read/write and resets to 0.
// (R02) In channels 0 and 3 bit 3 enables the D match request, reset 0.
// (R03) In channels 1, 2, 4 and 5 bit 3 reads as 0 and ignores writes.
// (R04) In channels 0 and 3 bit 2 enables the C match request, reset 0.
// (R05) In channels 1, 2, 4 and 5 bit 2 reads as 0 and ignores writes.
// (R06) In channels 1, 2, 4 and 5 the underflow enable gates underflow.
// (R07) In channels 0 and 3 bit 5 has no underflow function, reserved.
// (R08) Each request is its flag AND its enable and drops with either.
// (R09) Bit 5 reads 0 in channels 0 and 3, read/write reset 0 elsewhere.
module tig_timer_irq_gate
#(
    parameter int unsigned CHANNEL = 0
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer status flags
    input  wire logic        overflow_flag,
    input  wire logic        underflow_flag,
    input  wire logic        match_c_flag,
    input  wire logic        match_d_flag,
    // Interrupt requests
    output logic             overflow_irq,
    output logic             underflow_irq,
    output logic             match_c_irq,
    output logic             match_d_irq,
    output logic             irq
);

    // -------------------------------------------------------------
    // Channel shape
    // -------------------------------------------------------------
    localparam tig_pkg::tig_field_t WMASK =
        tig_pkg::writable_mask(CHANNEL);
    localparam logic HAS_CD = tig_pkg::has_match_cd(CHANNEL);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        tig_pkg::tig_field_t enable;
        tig_pkg::tig_field_t status;
        tig_pkg::tig_field_t mask;
        logic                irq;
    } tig_core_s;

    tig_core_s           st_r;
    tig_core_s           st_nxt;
    tig_pkg::tig_field_t flags;
    tig_pkg::tig_field_t irq_req;
    tig_pkg::tig_field_t evt;
    logic                wr_enable;
    logic                wr_mask;
    logic                rd_status;

    tig_reg_if rb ();

    // -------------------------------------------------------------
    // Bus front end
    // -------------------------------------------------------------
    tig_apb_slave u_apb
    (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rb      (rb.bus)
    );

    // -------------------------------------------------------------
    // Flag layout and gating
    // -------------------------------------------------------------
    always_comb
    begin
        flags                         = 6'h00;
        flags[tig_pkg::BIT_MATCH_C]   = match_c_flag;
        flags[tig_pkg::BIT_MATCH_D]   = match_d_flag;
        flags[tig_pkg::BIT_OVERFLOW]  = overflow_flag;
        flags[tig_pkg::BIT_UNDERFLOW] = underflow_flag;
    end

    tig_gate u_gate
    (
        .pclk    (pclk),
        .presetn (presetn),
        .flags   (flags),
        .enable  (st_r.enable),
        .irq_req (irq_req),
        .evt     (evt)
    );

    // -------------------------------------------------------------
    // Register decode and read mux
    // -------------------------------------------------------------
    assign wr_enable = rb.wr_pulse && (rb.addr == tig_pkg::ADDR_IRQ_ENABLE);
    assign wr_mask   = rb.wr_pulse && (rb.addr == tig_pkg::ADDR_EVENT_MASK);
    assign rd_status = rb.rd_pulse &&
                       (rb.addr == tig_pkg::ADDR_EVENT_STATUS);

    always_comb
    begin
        rb.hit   = 1'b1;
        rb.rdata = tig_pkg::RDATA_RST;
        case (rb.addr)
            tig_pkg::ADDR_IRQ_ENABLE:
                rb.rdata[5:0] = st_r.enable;
            tig_pkg::ADDR_FLAGS:
                rb.rdata[5:0] = flags & WMASK;
            tig_pkg::ADDR_EVENT_STATUS:
                // Show an event landing on the setup edge too
                rb.rdata[5:0] = st_nxt.status;
            tig_pkg::ADDR_EVENT_MASK:
                rb.rdata[5:0] = st_r.mask;
            default:
                rb.hit = 1'b0;
        endcase
    end

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // Absent functions keep their bits at zero
        if (wr_enable)
            st_nxt.enable = rb.wdata[5:0] & WMASK;  // R03 R05 R07 R09
        if (wr_mask)
            st_nxt.mask = rb.wdata[5:0] & WMASK;
        // A new event wins over the clearing read
        if (rd_status)
            st_nxt.status = evt & WMASK;
        else
            st_nxt.status = st_r.status | (evt & WMASK);
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '{enable: tig_pkg::IRQ_ENABLE_RST,
                      status: tig_pkg::EVENT_RST,
                      mask:   tig_pkg::EVENT_RST,
                      irq:    1'b0};
        else
            st_r <= st_nxt;
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign overflow_irq  = irq_req[tig_pkg::BIT_OVERFLOW];   // R01
    assign underflow_irq = irq_req[tig_pkg::BIT_UNDERFLOW];  // R06
    assign match_c_irq   = irq_req[tig_pkg::BIT_MATCH_C];    // R04
    assign match_d_irq   = irq_req[tig_pkg::BIT_MATCH_D];    // R02
    assign irq           = st_r.irq;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence wr_enable_s;
        wr_enable;
    endsequence

    sequence rd_status_s;
        rd_status;
    endsequence

    property enable_lands_p;
        logic [5:0] d;
        (wr_enable_s, d = rb.wdata[5:0]) |=> st_r.enable == (d & WMASK);
    endproperty

    overflow_gate_a: assert property ( // R01
        ##1 overflow_irq == $past(overflow_flag &&
                                  st_r.enable[tig_pkg::BIT_OVERFLOW]))
        else $error("Overflow request not flag AND enable");

    overflow_write_a: assert property ( // R01
        wr_enable && rb.wdata[4] |=> ##1
        (overflow_irq == $past(overflow_flag)))
        else $error("Overflow enable write not effective");

    match_d_gate_a: assert property ( // R02
        ##1 match_d_irq == $past(match_d_flag && HAS_CD &&
                                 st_r.enable[tig_pkg::BIT_MATCH_D]))
        else $error("D match request gating wrong");

    match_d_rsvd_a: assert property ( // R03
        !HAS_CD |-> !st_r.enable[tig_pkg::BIT_MATCH_D] && !match_d_irq)
        else $error("Reserved D enable bit set");

    match_c_gate_a: assert property ( // R04
        ##1 match_c_irq == $past(match_c_flag && HAS_CD &&
                                 st_r.enable[tig_pkg::BIT_MATCH_C]))
        else $error("C match request gating wrong");

    match_c_rsvd_a: assert property ( // R05
        !HAS_CD |-> !st_r.enable[tig_pkg::BIT_MATCH_C] && !match_c_irq)
        else $error("Reserved C enable bit set");

    underflow_gate_a: assert property ( // R06
        ##1 underflow_irq == $past(underflow_flag && !HAS_CD &&
                                   st_r.enable[tig_pkg::BIT_UNDERFLOW]))
        else $error("Underflow request gating wrong");

    underflow_rsvd_a: assert property ( // R07
        HAS_CD |-> !st_r.enable[tig_pkg::BIT_UNDERFLOW] && !underflow_irq)
        else $error("Reserved underflow enable bit set");

    enable_drop_a: assert property ( // R08
        $fell(st_r.enable[tig_pkg::BIT_OVERFLOW]) |=> !overflow_irq)
        else $error("Request held after enable cleared");

    flag_drop_a: assert property ( // R08
        !overflow_flag |=> !overflow_irq [*1])
        else $error("Request held after flag cleared");

    enable_write_a: assert property (enable_lands_p) // R09
        else $error("Enable write did not land masked");

    status_clear_a: assert property (
        rd_status_s ##0 (evt == 6'h00) |=> st_r.status == 6'h00)
        else $error("Status not cleared by read");

    status_sticky_a: assert property (
        !rd_status && (st_r.status != 6'h00) |=>
        ($past(st_r.status) & ~st_r.status) == 6'h00)
        else $error("Status bit lost without read");

    irq_line_a: assert property (
        irq == |(st_r.status & st_r.mask))
        else $error("Interrupt line disagrees with status and mask");

    // -------------------------------------------------------------
    // Register access checks
    // -------------------------------------------------------------

    sequence setup_s;
        psel && !penable;
    endsequence

    sequence access_s;
        psel && penable && pready;
    endsequence

    sequence read_of_s(logic [7:0] a);
        setup_s ##0 (!pwrite && paddr == a);
    endsequence

    property mask_lands_p;
        logic [5:0] d;
        (wr_mask, d = rb.wdata[5:0]) |=> st_r.mask == (d & WMASK);
    endproperty

    answer_one_a: assert property (
        access_s |=> !pready)
        else $error("Ready held past the access cycle");

    unmapped_err_a: assert property (
        setup_s ##0 !rb.hit |=> pslverr && prdata == 32'h0000_0000)
        else $error("Unmapped address not refused");

    mapped_ok_a: assert property (
        setup_s ##0 rb.hit |=> !pslverr)
        else $error("Error raised on a mapped address");

    write_data_a: assert property (
        pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("Read data not zero on a write");

    upper_zero_a: assert property (
        pready |-> prdata[31:6] == 26'h000_0000)
        else $error("Upper read data bits not zero");

    enable_read_a: assert property ( // R03 R05 R07 R09
        read_of_s(tig_pkg::ADDR_IRQ_ENABLE) |=>
        prdata[5:0] == st_r.enable && (prdata[5:0] & ~WMASK) == 6'h00)
        else $error("Enable readback wrong or reserved bit set");

    mask_read_a: assert property (
        read_of_s(tig_pkg::ADDR_EVENT_MASK) |=> prdata[5:0] == st_r.mask)
        else $error("Mask readback wrong");

    flags_read_a: assert property (
        read_of_s(tig_pkg::ADDR_FLAGS) |=>
        prdata[5:0] == $past(flags & WMASK))
        else $error("Flag readback wrong");

    status_read_a: assert property (
        read_of_s(tig_pkg::ADDR_EVENT_STATUS) |=>
        prdata[5:0] == st_r.status)
        else $error("Status read misses a pending event");

    enable_hold_a: assert property ( // R01
        !wr_enable |=> $stable(st_r.enable))
        else $error("Enable changed without a write");

    mask_hold_a: assert property (
        !wr_mask |=> $stable(st_r.mask))
        else $error("Mask changed without a write");

    mask_write_a: assert property (mask_lands_p)
        else $error("Mask write did not land masked");

    event_sets_a: assert property (
        (evt & WMASK) != 6'h00 |=>
        (st_r.status & $past(evt & WMASK)) == $past(evt & WMASK))
        else $error("Event did not set its status bit");

    status_rsvd_a: assert property ( // R03 R05 R07 R09
        (st_r.status & ~WMASK) == 6'h00 && (st_r.mask & ~WMASK) == 6'h00)
        else $error("Reserved status or mask bit set");

    rsvd_request_a: assert property ( // R03 R05 R07
        (irq_req & ~WMASK) == 6'h00)
        else $error("Request raised on an absent function");

    underflow_drop_a: assert property ( // R08
        !underflow_flag |=> !underflow_irq)
        else $error("Underflow request held after flag cleared");

    match_c_drop_a: assert property ( // R08
        !match_c_flag |=> !match_c_irq)
        else $error("C match request held after flag cleared");

    match_d_drop_a: assert property ( // R08
        !match_d_flag |=> !match_d_irq)
        else $error("D match request held after flag cleared");

endmodule // tig_timer_irq_gate

// ---- tig_intc_model.sv ----
// Interrupt controller model latching requests from one timer channel
`timescale 1ns/1ns
module tig_intc_model
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Requests in and acknowledge
    input  wire logic [4:0] req,
    input  wire logic       ack,
    // Latched pending requests
    output logic      [4:0] pending
);
    // Level requests are latched until acknowledged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pending <= 5'h00;
        else if (ack)
            pending <= req;
        else
            pending <= pending | req;
    end
endmodule // tig_intc_model

// ---- timer_irq_enable_gating_tb.sv ----
// Self-checking bench for the timer interrupt gate, channels 0 and 1
`timescale 1ns/1ns
module timer_irq_enable_gating_tb;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic                  pclk;
    logic                  presetn;
    logic [1:0]            psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [1:0][31:0]      prdata;
    logic [1:0]            pready;
    logic [1:0]            pslverr;
    logic [3:0]            flg;   // Overflow, underflow, match C, match D
    logic [1:0][4:0]       irqs;  // Summary irq, then as flg
    logic [4:0]            pend;
    logic                  ack;
    logic [31:0]           lfsr_r;
    logic [31:0]           rd;
    logic                  er;
    logic [5:0]            en;
    int                    err_total;
    int                    checked;

    for (genvar g = 0; g < 2; g++)
    begin : ch
        tig_timer_irq_gate #(.CHANNEL(g)) dut_u
        (
            .pclk(pclk), .presetn(presetn), .psel(psel[g]),
            .penable(penable), .pwrite(pwrite), .paddr(paddr),
            .pwdata(pwdata), .prdata(prdata[g]), .pready(pready[g]),
            .pslverr(pslverr[g]), .overflow_flag(flg[3]),
            .underflow_flag(flg[2]), .match_c_flag(flg[1]),
            .match_d_flag(flg[0]), .irq(irqs[g][4]),
            .overflow_irq(irqs[g][3]), .underflow_irq(irqs[g][2]),
            .match_c_irq(irqs[g][1]), .match_d_irq(irqs[g][0])
        );
    end

    tig_intc_model intc_u
    (
        .pclk(pclk), .presetn(presetn), .req(irqs[0]), .ack(ack),
        .pending(pend)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'ha300_0000 : 32'h0000_0000);
    endfunction

    // Bits that a channel keeps
    function automatic logic [5:0] exp_mask(input int s);
        return (s == 0) ? 6'h1c : 6'h30;
    endfunction

    // Expected requests: overflow, underflow, match C, match D
    function automatic logic [3:0] gate(input int s, input logic [5:0] e,
                                        input logic [3:0] f);
        logic [5:0] m;
        m = e & exp_mask(s);
        return {f[3] & m[4], f[2] & m[5], f[1] & m[2], f[0] & m[3]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; read data and error land in rd and er
    task automatic apb(input int s, input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel[s] <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready[s] !== 1'b1 && n < 20);
        if (n >= 20)
            chk("pready", 32'h0000_0000, 32'h0000_0001);
        rd = prdata[s];
        er = pslverr[s];
        psel[s] <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        err_total = 0;
        checked = 0;
        lfsr_r = 32'h0001_4271;
        presetn = 1'b0;
        psel = 2'b00;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        flg = 4'h0;
        ack = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int s = 0; s < 2; s++)
            for (int a = 0; a < 16; a += 4)
            begin
                apb(s, 1'b0, 8'(a), 32'h0000_0000);
                chk("reset value", rd, 32'h0000_0000);
            end
        $display("Test reset values done");
        for (int s = 0; s < 2; s++)
        begin
            apb(s, 1'b1, 8'h00, 32'hffff_ffff);
            apb(s, 1'b0, 8'h00, 32'h0000_0000);
            chk("enable readback", rd, 32'(exp_mask(s)));
            apb(s, 1'b1, 8'h00, 32'h0000_0000);
            apb(s, 1'b0, 8'h00, 32'h0000_0000);
            chk("enable cleared", rd, 32'h0000_0000);
        end
        $display("Test reserved bits done");
        for (int i = 0; i < 40; i++)
        begin
            lfsr_r = lfsr(lfsr_r);
            en = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : lfsr_r[9:4];
            @(posedge pclk);
            flg <= (i == 0) ? 4'hf : lfsr_r[3:0];
            apb(0, 1'b1, 8'h00, 32'(en));
            apb(1, 1'b1, 8'h00, 32'(en));
            settle(2);
            for (int s = 0; s < 2; s++)
                chk("req", 32'(irqs[s][3:0]), 32'(gate(s, en, flg)));
            chk("underflow", 32'(irqs[1][2]), 32'(flg[2] & en[5]));
            chk("ch0 underflow", 32'(irqs[0][2]), 32'h0000_0000);
        end
        $display("Test random gating done");
        @(posedge pclk);
        flg <= 4'h0;
        apb(0, 1'b1, 8'h00, 32'h0000_0010);
        apb(0, 1'b1, 8'h0c, 32'h0000_0010);
        apb(0, 1'b0, 8'h08, 32'h0000_0000);
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        flg <= 4'h8;
        settle(3);
        chk("irq raised", 32'(irqs[0][4]), 32'h0000_0001);
        chk("controller", 32'(pend[3]), 32'h0000_0001);
        apb(0, 1'b0, 8'h08, 32'h0000_0000);
        chk("event status", rd, 32'h0000_0010);
        settle(2);
        chk("irq cleared", 32'(irqs[0][4]), 32'h0000_0000);
        apb(0, 1'b1, 8'h0c, 32'h0000_0000);
        flg <= 4'h0;
        settle(2);
        chk("request drops", 32'(irqs[0][3]), 32'h0000_0000);
        @(posedge pclk);
        flg <= 4'h8;
        settle(3);
        chk("irq masked", 32'(irqs[0][4]), 32'h0000_0000);
        apb(0, 1'b0, 8'h08, 32'h0000_0000);
        chk("masked status", rd, 32'h0000_0010);
        $display("Test interrupt done");
        apb(1, 1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped error", 32'(er), 32'h0000_0001);
        chk("unmapped data", rd, 32'h0000_0000);
        $display("Test unmapped done");
        conclude();
    end

    initial
    begin
        #200000;
        err_total++;
        conclude();
    end
endmodule // timer_irq_enable_gating_tb
